// >>> hw/apms_seq.sv
// top: activity-driven power mode sequencer with radio and oscillator control
`timescale 1ns/100ps
`default_nettype none
module apms_seq
    import apms_pkg::*;
#(
    parameter int unsigned N_PERIPH = 4
) (
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_user_event,
    input  wire logic [APMS_TMR_W-1:0] i_idle_period,
    input  wire logic [APMS_TMR_W-1:0] i_sleep_period,
    input  wire logic [APMS_TMR_W-1:0] i_off_period,
    input  wire logic                  i_sw_force_down,
    input  wire logic                  i_fw_ldo_off_en,
    input  wire logic                  i_pkt_tx,
    input  wire logic                  i_pkt_rx,
    input  wire logic                  i_pkt_wake,
    input  wire logic                  i_sniff_en,
    input  wire logic [APMS_TMR_W-1:0] i_sniff_interval,
    input  wire logic [N_PERIPH-1:0]   i_periph_en,
    input  wire logic [N_PERIPH-1:0]   i_periph_clk_req,
    output logic [3:0]                 o_power_state,
    output logic                       o_core_ldo_en,
    output logic                       o_tx_pd,
    output logic                       o_rx_pd,
    output logic                       o_pll_pd,
    output logic                       o_pa_pd,
    output logic                       o_slow_osc_en,
    output logic                       o_slow_clk,
    output logic                       o_on_slow_clk,
    output logic                       o_sniff_wake
);
    if (N_PERIPH < 1 || N_PERIPH > 32) begin : g_bad_periph
        $error("N_PERIPH out of range");
    end

    apms_state_t           state_q;
    apms_state_t           state_d;
    logic [APMS_TMR_W-1:0] idle_cnt_q;
    logic [APMS_TMR_W-1:0] limit;
    logic                  evt_s1_q;
    logic                  evt_s2_q;
    logic                  evt_s3_q;
    logic                  activity;
    logic                  expired;
    logic [APMS_TMR_W-1:0] sniff_cnt_q;
    logic                  sniff_wake_q;
    logic [APMS_DIV_W-1:0] div_q;
    logic                  slow_clk_q;
    logic                  osc_req;
    logic [N_PERIPH-1:0]   req_gated;
    logic                  ldo_en_d;

    apms_rf_if rf ();

    // user event pin synchronised, rising edge is activity
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            evt_s1_q <= 1'b0;
            evt_s2_q <= 1'b0;
            evt_s3_q <= 1'b0;
        end else begin
            evt_s1_q <= i_user_event;
            evt_s2_q <= evt_s1_q;
            evt_s3_q <= evt_s2_q;
        end
    end

    // always-on domain watches events in every state
    assign activity = (evt_s2_q && !evt_s3_q) || i_pkt_wake;

    always_comb begin
        unique case (state_q)
            APMS_ACTIVE: limit = i_idle_period;
            APMS_IDLE:   limit = i_sleep_period;
            APMS_SLEEP:  limit = i_off_period;
            default:     limit = '1;
        endcase
    end

    assign expired = (idle_cnt_q >= limit) && (state_q != APMS_OFF);

    // inactivity timer
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            idle_cnt_q <= '0;
        end else if (activity || expired || i_sw_force_down) begin
            idle_cnt_q <= '0;
        end else if (state_q != APMS_OFF) begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end
    end

    // next power state
    always_comb begin
        state_d = state_q;
        if (activity) begin
            state_d = APMS_ACTIVE;
        end else if (expired || i_sw_force_down) begin
            unique case (state_q)
                APMS_ACTIVE: state_d = APMS_IDLE;
                APMS_IDLE:   state_d = APMS_SLEEP;
                APMS_SLEEP:  state_d = APMS_OFF;
                APMS_OFF:    state_d = APMS_OFF;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= APMS_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_power_state = state_q;

    // core regulator output, dropped only when firmware allows it
    assign ldo_en_d = !((state_d == APMS_OFF) && i_fw_ldo_off_en);

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_core_ldo_en <= 1'b1;
        end else begin
            o_core_ldo_en <= ldo_en_d;
        end
    end

    // radio gate sees the next regulator state, so it goes dark on the same edge
    assign rf.core_on = ldo_en_d;

    apms_rf_gate u_rf_gate (
        .i_mclk   (i_mclk),
        .i_rst_b  (i_rst_b),
        .i_pkt_tx (i_pkt_tx),
        .i_pkt_rx (i_pkt_rx),
        .rf       (rf.gate)
    );

    assign o_tx_pd  = rf.tx_pd;
    assign o_rx_pd  = rf.rx_pd;
    assign o_pll_pd = rf.pll_pd;
    assign o_pa_pd  = rf.pa_pd;

    // peripheral requests gated by their enables
    genvar g;
    generate
        for (g = 0; g < N_PERIPH; g++) begin : g_req
            assign req_gated[g] = i_periph_en[g] && i_periph_clk_req[g];
        end
    endgenerate

    assign osc_req = (|req_gated) || (i_sniff_en && state_q != APMS_ACTIVE);

    // slow oscillator model: divided clock while requested
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_q      <= '0;
            slow_clk_q <= 1'b0;
        end else if (!osc_req) begin
            div_q      <= '0;
            slow_clk_q <= 1'b0;
        end else if (div_q == APMS_DIV_W'(APMS_SLOW_DIV - 1)) begin
            div_q      <= '0;
            slow_clk_q <= !slow_clk_q;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_slow_osc_en <= 1'b0;
        end else begin
            o_slow_osc_en <= osc_req;
        end
    end

    assign o_slow_clk = slow_clk_q;

    // sniff: run on slow clock, wake after interval plus one slow ticks
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sniff_cnt_q  <= '0;
            sniff_wake_q <= 1'b0;
            o_on_slow_clk <= 1'b0;
        end else begin
            o_on_slow_clk <= i_sniff_en && (state_q != APMS_ACTIVE);
            sniff_wake_q  <= 1'b0;
            if (!i_sniff_en || state_q == APMS_ACTIVE) begin
                sniff_cnt_q <= '0;
            end else if (div_q == APMS_DIV_W'(APMS_SLOW_DIV - 1) && !slow_clk_q) begin
                if (sniff_cnt_q >= i_sniff_interval) begin
                    sniff_cnt_q  <= '0;
                    sniff_wake_q <= 1'b1;
                end else begin
                    sniff_cnt_q <= sniff_cnt_q + 1'b1;
                end
            end
        end
    end

    assign o_sniff_wake = sniff_wake_q;
endmodule
`default_nettype wire

// >>> hw/apms_pkg.sv
// package: constants and types for the activity power mode sequencer
package apms_pkg;
    localparam int unsigned APMS_CLK_HZ        = 250_000_000;
    localparam int unsigned APMS_SLOW_OSC_HZ   = 128_000;
    localparam int unsigned APMS_SLOW_DIV      = APMS_CLK_HZ / (2 * APMS_SLOW_OSC_HZ);
    localparam int unsigned APMS_TMR_W         = 32;
    localparam int unsigned APMS_DIV_W         = 16;
    localparam logic [31:0] APMS_IDLE_RST      = 32'h0000_1000;
    localparam logic [31:0] APMS_SLEEP_RST     = 32'h0000_4000;
    localparam logic [31:0] APMS_OFF_RST       = 32'h0001_0000;
    localparam logic [31:0] APMS_SNIFF_RST     = 32'h0000_0400;

    typedef enum logic [3:0] {
        APMS_ACTIVE = 4'h1,
        APMS_IDLE   = 4'h2,
        APMS_SLEEP  = 4'h4,
        APMS_OFF    = 4'h8
    } apms_state_t;
endpackage

// >>> hw/apms_rf_if.sv
// interface: radio power-down controls between sequencer and radio gate
`timescale 1ns/100ps
`default_nettype none
interface apms_rf_if;
    logic tx_pd;
    logic rx_pd;
    logic pll_pd;
    logic pa_pd;
    logic core_on;
    modport ctrl (input tx_pd, rx_pd, pll_pd, pa_pd, output core_on);
    modport gate (output tx_pd, rx_pd, pll_pd, pa_pd, input core_on);
endinterface
`default_nettype wire

// >>> hw/apms_rf_gate.sv
// radio power-down gating driven by packet handling
`timescale 1ns/100ps
`default_nettype none
module apms_rf_gate
    import apms_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_rst_b,
    input  wire logic i_pkt_tx,
    input  wire logic i_pkt_rx,
    apms_rf_if.gate   rf
);
    // powered only while the packet handler needs the path
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rf.tx_pd  <= 1'b1;
            rf.rx_pd  <= 1'b1;
            rf.pll_pd <= 1'b1;
            rf.pa_pd  <= 1'b1;
        end else begin
            rf.tx_pd  <= !(rf.core_on && i_pkt_tx);
            rf.pa_pd  <= !(rf.core_on && i_pkt_tx);
            rf.rx_pd  <= !(rf.core_on && i_pkt_rx);
            rf.pll_pd <= !(rf.core_on && (i_pkt_tx || i_pkt_rx));
        end
    end
endmodule
`default_nettype wire

// >>> dv/apms_seq_props.sv
// checker: port-level assertions for the power mode sequencer
`timescale 1ns/100ps
`default_nettype none
module apms_seq_props
    import apms_pkg::*;
#(
    parameter int unsigned N_PERIPH = 4
) (
    input wire logic                i_mclk,
    input wire logic                i_rst_b,
    input wire logic                i_user_event,
    input wire logic                i_fw_ldo_off_en,
    input wire logic                i_pkt_tx,
    input wire logic                i_pkt_rx,
    input wire logic                i_pkt_wake,
    input wire logic [N_PERIPH-1:0] i_periph_en,
    input wire logic [N_PERIPH-1:0] i_periph_clk_req,
    input wire logic [3:0]          o_power_state,
    input wire logic                o_core_ldo_en,
    input wire logic                o_tx_pd,
    input wire logic                o_rx_pd,
    input wire logic                o_pll_pd,
    input wire logic                o_pa_pd,
    input wire logic                o_slow_osc_en,
    input wire logic                o_sniff_wake
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);
    chk_state_one_hot: assert property ($onehot(o_power_state))
        else $error("state not one-hot");
    chk_pkt_wake_up: assert property (i_pkt_wake |=> o_power_state == 4'h1)
        else $error("packet wake missed");
    chk_user_wake_up: assert property ($rose(i_user_event) |-> ##[2:4] o_power_state == 4'h1)
        else $error("user wake missed");
    chk_sleep_order: assert property (o_power_state == 4'h4 |-> $past(o_power_state) inside {4'h2, 4'h4})
        else $error("sleep entered out of order");
    chk_off_order: assert property (o_power_state == 4'h8 |-> $past(o_power_state) inside {4'h4, 4'h8})
        else $error("off entered out of order");
    chk_ldo_only_off: assert property (!o_core_ldo_en |-> o_power_state == 4'h8)
        else $error("regulator off outside power-off");
    chk_ldo_drop: assert property ($rose(o_power_state == 4'h8) && $past(i_fw_ldo_off_en) |-> !o_core_ldo_en)
        else $error("regulator kept on");
    chk_radio_dark: assert property (!o_core_ldo_en |-> o_tx_pd && o_rx_pd && o_pll_pd && o_pa_pd)
        else $error("radio powered without core");
    chk_radio_follow: assert property (o_core_ldo_en && $past(o_core_ldo_en)
        |-> o_tx_pd == !$past(i_pkt_tx) && o_rx_pd == !$past(i_pkt_rx)
        && o_pll_pd == !($past(i_pkt_tx) || $past(i_pkt_rx)) && o_pa_pd == !$past(i_pkt_tx))
        else $error("radio power-down wrong");
    chk_osc_request: assert property (|($past(i_periph_en) & $past(i_periph_clk_req))
        |-> o_slow_osc_en)
        else $error("oscillator request lost");
    chk_wake_pulse: assert property (o_sniff_wake |=> !o_sniff_wake)
        else $error("sniff wake too long");
    cov_off: cover property (!o_core_ldo_en);
    cov_wake: cover property (o_sniff_wake);
    cov_user: cover property ($rose(i_user_event) ##3 o_power_state == 4'h1);
endmodule
bind apms_seq apms_seq_props #(.N_PERIPH(N_PERIPH)) u_props (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_user_event(i_user_event), .i_fw_ldo_off_en(i_fw_ldo_off_en), .i_pkt_tx(i_pkt_tx),
    .i_pkt_rx(i_pkt_rx), .i_pkt_wake(i_pkt_wake), .i_periph_en(i_periph_en),
    .i_periph_clk_req(i_periph_clk_req), .o_power_state(o_power_state),
    .o_core_ldo_en(o_core_ldo_en), .o_tx_pd(o_tx_pd), .o_rx_pd(o_rx_pd), .o_pll_pd(o_pll_pd),
    .o_pa_pd(o_pa_pd), .o_slow_osc_en(o_slow_osc_en), .o_sniff_wake(o_sniff_wake));
`default_nettype wire

// >>> dv/apms_user_src.sv
// partner: user input source holding each press on the event pin
`timescale 1ns/100ps
`default_nettype none
module apms_user_src (
    input  wire logic i_mclk,
    input  wire logic i_press,
    output wire logic o_pin
);
    logic [2:0] cnt_q = 3'h0;
    logic       pin_q = 1'b0;
    // press taken at the rising edge, pin moved at the falling edge
    always @(posedge i_mclk) begin
        if (i_press) cnt_q <= 3'h4;
        else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
    end
    always @(negedge i_mclk) begin
        pin_q <= (cnt_q != 3'h0);
    end
    assign o_pin = pin_q;
endmodule
`default_nettype wire

// >>> dv/apms_seq_tb_top.sv
// testbench: random and corner stimulus for the power mode sequencer
`timescale 1ns/100ps
`default_nettype none
module apms_seq_tb_top;
    import apms_pkg::*;
    logic        i_mclk, i_rst_b, i_sw_force_down, i_fw_ldo_off_en, i_pkt_tx, i_pkt_rx;
    logic        i_pkt_wake, i_sniff_en, press, pin, ldo, txp, rxp, pllp, pap, osc, wake, slw, sclk;
    logic [31:0] idle_p, sleep_p, off_p, sniff_iv;
    logic [3:0]  en, req, st;
    int          err_total = 0, total_checks = 0, r;
    apms_user_src u_src (.i_mclk(i_mclk), .i_press(press), .o_pin(pin));
    apms_seq uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_user_event(pin),
        .i_idle_period(idle_p), .i_sleep_period(sleep_p), .i_off_period(off_p),
        .i_sw_force_down(i_sw_force_down), .i_fw_ldo_off_en(i_fw_ldo_off_en),
        .i_pkt_tx(i_pkt_tx), .i_pkt_rx(i_pkt_rx), .i_pkt_wake(i_pkt_wake),
        .i_sniff_en(i_sniff_en), .i_sniff_interval(sniff_iv), .i_periph_en(en),
        .i_periph_clk_req(req), .o_power_state(st), .o_core_ldo_en(ldo), .o_tx_pd(txp),
        .o_rx_pd(rxp), .o_pll_pd(pllp), .o_pa_pd(pap), .o_slow_osc_en(osc), .o_slow_clk(sclk),
        .o_on_slow_clk(slw), .o_sniff_wake(wake));
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    task automatic wrap_up;
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wait_for(input logic [3:0] s);
        int n;
        n = 0;
        while (st !== s) begin
            @(negedge i_mclk);
            n++;
            if (n > 30000) begin
                chk(st, s);
                wrap_up();
            end
        end
    endtask
    task automatic dwell(input logic [31:0] exp);
        logic [3:0]  s;
        logic [31:0] n;
        s = st;
        n = 32'h0;
        while (st === s && n < 32'h7530) begin
            @(negedge i_mclk);
            n++;
        end
        chk(n, exp);
        if (n == 32'h7530) begin
            wrap_up();
        end
    endtask
    task automatic slow_edge(output int n);
        logic s;
        s = sclk;
        n = 0;
        while (sclk === s && n < 4000) begin
            @(negedge i_mclk);
            n++;
        end
    endtask
    task automatic pulse_wake;
        i_pkt_wake = 1'b1;
        @(negedge i_mclk);
        i_pkt_wake = 1'b0;
    endtask
    initial begin
        {i_rst_b, i_sw_force_down, i_fw_ldo_off_en, i_pkt_tx, i_pkt_rx} = 5'h00;
        {i_pkt_wake, i_sniff_en, press, en, req} = 11'h000;
        void'($urandom(32'h132C8258));
        idle_p = 32'h2 + $urandom % 6;
        sleep_p = 32'h2 + $urandom % 6;
        off_p = 32'h3;
        sniff_iv = 32'h2;
        repeat (8) @(negedge i_mclk);
        chk({st, ldo, txp, rxp, pllp, pap}, 9'h03F);
        i_rst_b = 1'b1;
        for (r = 0; r < 4; r++) begin
            i_fw_ldo_off_en = r[0];
            wait_for(APMS_IDLE);
            repeat (idle_p / 2) @(negedge i_mclk);
            pulse_wake();
            chk(st, APMS_ACTIVE);
            dwell(idle_p + 32'h1);
            dwell(sleep_p + 32'h1);
            dwell(off_p + 32'h1);
            repeat (40) @(negedge i_mclk);
            chk({st, ldo}, {APMS_OFF, ~r[0]});
            press = 1'b1;
            @(negedge i_mclk);
            press = 1'b0;
            wait_for(APMS_ACTIVE);
            i_sw_force_down = 1'b1;
            @(negedge i_mclk);
            i_sw_force_down = 1'b0;
            chk(st, APMS_IDLE);
        end
        idle_p = 32'h0000_3000;
        sleep_p = 32'h0000_3000;
        pulse_wake();
        for (r = 0; r < 24; r++) begin
            {i_pkt_tx, i_pkt_rx} = 2'($urandom);
            en = 4'($urandom);
            req = 4'($urandom);
            @(negedge i_mclk);
            chk({txp, rxp, pllp, pap}, {~i_pkt_tx, ~i_pkt_rx, ~(i_pkt_tx | i_pkt_rx), ~i_pkt_tx});
            chk(osc, |(en & req));
        end
        i_sw_force_down = 1'b1;
        @(negedge i_mclk);
        i_sw_force_down = 1'b0;
        i_sniff_en = 1'b1;
        r = 0;
        while (wake !== 1'b1 && r < 20000) begin
            @(negedge i_mclk);
            r++;
        end
        chk({wake, slw}, 2'h3);
        @(negedge i_mclk);
        chk(wake, 1'b0);
        slow_edge(r);
        slow_edge(r);
        chk(r, APMS_SLOW_DIV);
        wrap_up();
    end
endmodule
`default_nettype wire
